// ### verilog/oes_top.sv
//
// Purpose: Enable-pin muxing, serial side-band shift path and output gating
// Assumes: All pins asynchronous to clk_i; APB slave with zero wait states
// Notes:   Serial clock is sampled, not used as a clock; keep it at most 25 MHz
//
// The register addresses and register access over APB were chosen for this implementation.
`default_nettype none

module oes_top
	import oes_pkg::*;
#(
	parameter int unsigned N_OUT        = NUM_OUTPUTS,
	parameter bit          HAS_SIDEBAND = 1'b1
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	// APB slave
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [11:0]      paddr_i,
	input  wire logic [31:0]      pwdata_i,
	output logic      [31:0]      prdata_o,
	output logic                  pready_o,
	output logic                  pslverr_o,
	// Enable pins, active low
	input  wire logic             enable_pin_a_n_i,
	input  wire logic             enable_pin_b_n_i,
	input  wire logic             enable_pin_c_n_i,
	input  wire logic             enable_pin_d_or_serial_clock_i,
	input  wire logic             enable_pin_e_or_serial_in_i,
	input  wire logic             enable_pin_f_n_i,
	input  wire logic             enable_pin_g_or_shift_load_n_i,
	input  wire logic             enable_pin_h_or_serial_out_i,
	output logic                  enable_pin_h_or_serial_out_o,
	output logic                  enable_pin_h_or_serial_out_oe_o,
	// Straps and system pins
	input  wire logic             side_band_enable_strap_i,
	input  wire logic             smbus_enable_latch_n_i,
	input  wire logic             power_good_powerdown_n_i,
	input  wire logic             reference_input_clock_i,
	// Gated output enables
	output logic      [N_OUT-1:0] clk_enable_o
);

	// ************************************************************
	// Pin synchronisation
	// ************************************************************
	logic [SYNC_WIDTH-1:0] raw_pins;
	logic [SYNC_WIDTH-1:0] pins;
	logic [NUM_PINS-1:0]   pin_n;

	// Gather pins for the synchroniser
	assign raw_pins = {smbus_enable_latch_n_i, reference_input_clock_i,
		power_good_powerdown_n_i, side_band_enable_strap_i,
		enable_pin_h_or_serial_out_i, enable_pin_g_or_shift_load_n_i, enable_pin_f_n_i,
		enable_pin_e_or_serial_in_i, enable_pin_d_or_serial_clock_i,
		enable_pin_c_n_i, enable_pin_b_n_i, enable_pin_a_n_i};

	oes_sync3 #(
		.WIDTH   (SYNC_WIDTH),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.async_i  (raw_pins),
		.stable_o (pins)
	);

	assign pin_n = pins[NUM_PINS-1:0];

	// ************************************************************
	// Strap capture after reset release
	// ************************************************************
	oes_strap_state_type strap_state_reg;
	oes_strap_state_type strap_state_next;
	logic [1:0]          wait_cnt_reg;
	logic [1:0]          wait_cnt_next;
	logic                strap_reg;
	logic                smben_n_reg;
	logic                capture;

	// Wait for synchronisers to fill, capture once, then hold
	always_comb begin
		strap_state_next = strap_state_reg;
		wait_cnt_next    = wait_cnt_reg;
		case (strap_state_reg)
			ST_WAIT: begin
				wait_cnt_next = wait_cnt_reg + 2'd1;
				if (wait_cnt_reg == 2'(STRAP_WAIT_CYCLES)) begin // One more for agreement
					strap_state_next = ST_CAPT;
				end
			end
			ST_CAPT: begin
				strap_state_next = ST_RUN;
			end
			default: begin
				strap_state_next = ST_RUN;
			end
		endcase
	end

	assign capture = (strap_state_reg == ST_CAPT);

	// Strap is read once; later pin changes are ignored
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strap_state_reg <= ST_WAIT;
			wait_cnt_reg    <= 2'd0;
			strap_reg       <= 1'b0;
			smben_n_reg     <= 1'b1;
		end else begin
			strap_state_reg <= strap_state_next;
			wait_cnt_reg    <= wait_cnt_next;
			if (capture) begin
				strap_reg   <= HAS_SIDEBAND & pins[SY_STRAP];
				smben_n_reg <= HAS_SIDEBAND | pins[SY_SMBEN];
			end
		end
	end

	// ************************************************************
	// Side-band serial path
	// ************************************************************
	oes_sb_pins_type sb;
	logic            sclk_prev_reg;
	logic            load_prev_reg;
	logic            sclk_rise;
	logic            load_fall;
	logic            shift_en;
	logic [N_OUT-1:0] shift_reg;
	logic [N_OUT-1:0] shift_next;
	logic [N_OUT-1:0] sb_ctrl_reg;
	logic [N_OUT-1:0] readback_reg;

	// Repurposed pins d, e, g
	assign sb.sclk   = pins[SY_PIN_D];
	assign sb.sin    = pins[SY_PIN_E];
	assign sb.load_n = pins[SY_PIN_G];

	// Edges found by sampling; no reference clock needed
	assign sclk_rise  = sb.sclk & ~sclk_prev_reg;
	assign load_fall  = ~sb.load_n & load_prev_reg;
	assign shift_en   = strap_reg & sb.load_n & sclk_rise;
	// First bit ends in the top stage
	assign shift_next = {shift_reg[N_OUT-2:0], sb.sin};

	// Edge history
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sclk_prev_reg <= 1'b1;             // Matches synchroniser reset level
			load_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sb.sclk;
			load_prev_reg <= sb.load_n;
		end
	end

	// Shift register, loaded only by serial shifting
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_reg <= N_OUT'(SHIFT_RST);
		end else if (shift_en) begin
			shift_reg <= shift_next;
		end
	end

	// Latch to output control and bus copy on load falling edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sb_ctrl_reg  <= N_OUT'(SHIFT_RST);
			readback_reg <= N_OUT'(SHIFT_RST);
		end else if (strap_reg && load_fall) begin
			sb_ctrl_reg  <= shift_reg;
			readback_reg <= shift_reg;
		end
	end

	// Cascade output on pin h while strapped
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enable_pin_h_or_serial_out_o    <= 1'b0;
			enable_pin_h_or_serial_out_oe_o <= 1'b0;
		end else begin
			enable_pin_h_or_serial_out_o    <= shift_reg[N_OUT-1];
			enable_pin_h_or_serial_out_oe_o <= strap_reg;
		end
	end

	// ************************************************************
	// APB registers
	// ************************************************************
	logic [N_OUT-1:0]    out_en_reg;
	logic [N_OUT-1:0]    mask_reg;
	logic [NUM_PINS-1:0] pin_map_reg;
	logic                setup;
	logic                wr_acc;
	logic                hit_oe;
	logic                hit_mask;
	logic                hit_rb;
	logic                hit_map;
	logic                hit_stat;
	logic                mapped;
	logic [31:0]         rd_mux;
	logic [31:0]         status_word;

	// Address decode
	assign hit_oe   = (paddr_i == REG_OUTPUT_ENABLE);
	assign hit_mask = (paddr_i == REG_SB_MASK);
	assign hit_rb   = (paddr_i == REG_SB_READBACK);
	assign hit_map  = (paddr_i == REG_PIN_MAP);
	assign hit_stat = (paddr_i == REG_STATUS);
	assign mapped   = hit_oe | hit_mask | hit_rb | hit_map | hit_stat;
	assign setup    = psel_i & ~penable_i;
	assign wr_acc   = psel_i & penable_i & pwrite_i;

	// Zero wait states; unmapped addresses answer with an error
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	assign status_word = {13'h0000, ~smben_n_reg, pins[SY_PGOOD], strap_reg,
		16'(clk_enable_o)};

	// Read selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_oe) begin
			rd_mux = 32'(out_en_reg);
		end else if (hit_mask) begin
			rd_mux = 32'(mask_reg);
		end else if (hit_rb) begin
			rd_mux = 32'(readback_reg);
		end else if (hit_map) begin
			rd_mux = 32'(pin_map_reg);
		end else if (hit_stat) begin
			rd_mux = status_word;
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup && !pwrite_i) begin
			prdata_o <= rd_mux;
		end
	end

	// Writable registers; readback and status have no write path
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_en_reg  <= N_OUT'(OUTPUT_ENABLE_RST);
			mask_reg    <= N_OUT'(SB_MASK_RST);
			pin_map_reg <= PIN_MAP_RST;
		end else if (wr_acc) begin
			if (hit_oe) begin
				out_en_reg <= pwdata_i[N_OUT-1:0];
			end
			if (hit_mask && pins[SY_PGOOD]) begin
				mask_reg <= pwdata_i[N_OUT-1:0];
			end
			if (hit_map) begin
				pin_map_reg <= pwdata_i[NUM_PINS-1:0];
			end
		end
	end

	// ************************************************************
	// Enable combination
	// ************************************************************
	logic [NUM_PINS-1:0] pin_taken;
	logic [NUM_PINS-1:0] pin_on;
	logic [N_OUT-1:0]    pin_req;
	logic [N_OUT-1:0]    sb_req;
	logic [N_OUT-1:0]    target;

	// Pins lost to side-band or SMBus do not gate outputs
	assign pin_taken = ({NUM_PINS{strap_reg}} & SB_PIN_MASK) |
		({NUM_PINS{~smben_n_reg}} & SMB_PIN_MASK);
	assign pin_on    = ~pin_n | pin_taken;

	// Pin k drives output 2k, or 2k+1 when its map bit is set
	always_comb begin
		pin_req = '1;
		for (int k = 0; k < NUM_PINS; k++) begin
			if (2 * k + 1 < N_OUT) begin
				if (pin_map_reg[k]) begin
					pin_req[2 * k + 1] = pin_on[k];
				end else begin
					pin_req[2 * k] = pin_on[k];
				end
			end
		end
	end

	// Side-band request, masked, and void without the strap
	assign sb_req = strap_reg ? (sb_ctrl_reg | mask_reg) : '1;
	assign target = sb_req & pin_req & out_en_reg;

	// ************************************************************
	// Glitch-free gating on the reference clock
	// ************************************************************
	logic refclk_prev_reg;
	logic refclk_rise;

	assign refclk_rise = pins[SY_REFCLK] & ~refclk_prev_reg;

	// Enables move only on reference clock edges; stalled clock holds them
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			refclk_prev_reg <= 1'b0;
			clk_enable_o    <= '0;
		end else begin
			refclk_prev_reg <= pins[SY_REFCLK];
			if (refclk_rise) begin
				clk_enable_o <= target;
			end
		end
	end

	// Serial clock limit is the controller's duty; edges need this many samples
	logic unused_timing;
	assign unused_timing = (SB_CLK_MIN_CYCLES > 0);

endmodule

`default_nettype wire

// ### inc/oes_pkg.sv
//
// Purpose: Shared constants and types for the output-enable side-band block
// Assumes: 32-bit APB register access, one aligned word per register
// Notes:   Byte offsets, reset values and pin positions live here only
//
`default_nettype none

package oes_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int unsigned NUM_OUTPUTS  = 16;       // Clock outputs and shift stages
	localparam int unsigned NUM_PINS     = 8;        // Enable pins a..h
	localparam int unsigned SYNC_WIDTH   = 12;       // Pins plus straps plus ref clock

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [11:0] REG_OUTPUT_ENABLE = 12'h000; // Software enable per output
	localparam logic [11:0] REG_SB_MASK       = 12'h004; // Side-band disable mask
	localparam logic [11:0] REG_SB_READBACK   = 12'h008; // Copy of shift register
	localparam logic [11:0] REG_PIN_MAP       = 12'h00C; // Pin mapping select
	localparam logic [11:0] REG_STATUS        = 12'h010; // Live state

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [NUM_OUTPUTS-1:0] OUTPUT_ENABLE_RST = 16'hFFFF;
	localparam logic [NUM_OUTPUTS-1:0] SB_MASK_RST       = 16'h0000;
	localparam logic [NUM_OUTPUTS-1:0] SHIFT_RST         = 16'hFFFF;
	localparam logic [NUM_PINS-1:0]    PIN_MAP_RST       = 8'h00;

	// ************************************************************
	// Status field positions
	// ************************************************************
	localparam int unsigned STAT_STRAP_BIT  = 16;
	localparam int unsigned STAT_PGOOD_BIT  = 17;
	localparam int unsigned STAT_SMBEN_BIT  = 18;

	// ************************************************************
	// Synchroniser bit positions
	// ************************************************************
	localparam int unsigned SY_PIN_D  = 3;           // Serial clock when strapped
	localparam int unsigned SY_PIN_E  = 4;           // Serial in when strapped
	localparam int unsigned SY_PIN_G  = 6;           // Shift-load when strapped
	localparam int unsigned SY_STRAP  = 8;
	localparam int unsigned SY_PGOOD  = 9;
	localparam int unsigned SY_REFCLK = 10;
	localparam int unsigned SY_SMBEN  = 11;
	localparam logic [SYNC_WIDTH-1:0] SYNC_RST = 12'h8FF; // Pins idle high, latch high

	// Pins taken by the side-band when strapped (d, e, g, h)
	localparam logic [NUM_PINS-1:0] SB_PIN_MASK  = 8'hD8;
	// Pins shared with SMBus on variants without side-band (a, b)
	localparam logic [NUM_PINS-1:0] SMB_PIN_MASK = 8'h03;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS     = 10;
	localparam int unsigned SB_CLK_MAX_MHZ    = 25;
	localparam int unsigned SB_CLK_MIN_NS     = 1000 / SB_CLK_MAX_MHZ;
	localparam int unsigned SB_CLK_MIN_CYCLES = (SB_CLK_MIN_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int unsigned STRAP_WAIT_CYCLES = 3;   // Let synchronisers fill after reset

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic sclk;
		logic sin;
		logic load_n;
	} oes_sb_pins_type;

	typedef enum logic [1:0] {
		ST_WAIT  = 2'b00,
		ST_CAPT  = 2'b01,
		ST_RUN   = 2'b11
	} oes_strap_state_type;

endpackage

`default_nettype wire

// ### verilog/oes_sync3.sv
//
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk_i
// Notes:   Output changes once stages two and three agree
//
`default_nettype none

module oes_sync3 #(
	parameter int unsigned     WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] stable_o
);

	logic [WIDTH-1:0] ff1_reg;
	logic [WIDTH-1:0] ff2_reg;
	logic [WIDTH-1:0] ff3_reg;
	logic [WIDTH-1:0] stable_next;

	// Take stage two where it agrees with stage three
	assign stable_next = (ff2_reg & ~(ff2_reg ^ ff3_reg)) | (stable_o & (ff2_reg ^ ff3_reg));

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ff1_reg  <= RST_VAL;
			ff2_reg  <= RST_VAL;
			ff3_reg  <= RST_VAL;
			stable_o <= RST_VAL;
		end else begin
			ff1_reg  <= async_i;
			ff2_reg  <= ff1_reg;
			ff3_reg  <= ff2_reg;
			stable_o <= stable_next;
		end
	end

endmodule

`default_nettype wire

// ### tb/oes_top_chk.sv
// Purpose: Port-level assertions for the enable side-band block
// Assumes: Strap static, APB slave with zero wait states
// Notes:   Bound to oes_top below the module
`default_nettype none

module oes_chk
	import oes_pkg::*;
#(
	parameter int unsigned N_OUT = NUM_OUTPUTS
) (
	input wire logic             clk_i,
	input wire logic             nrst_i,
	input wire logic             psel_i,
	input wire logic             penable_i,
	input wire logic             pwrite_i,
	input wire logic [11:0]      paddr_i,
	input wire logic [31:0]      prdata_o,
	input wire logic             pready_o,
	input wire logic             pslverr_o,
	input wire logic             enable_pin_a_n_i,
	input wire logic             enable_pin_g_or_shift_load_n_i,
	input wire logic             enable_pin_h_or_serial_out_o,
	input wire logic             enable_pin_h_or_serial_out_oe_o,
	input wire logic             side_band_enable_strap_i,
	input wire logic             reference_input_clock_i,
	input wire logic [N_OUT-1:0] clk_enable_o
);
	// ************************************************************
	// Helper counters
	// ************************************************************
	logic [3:0] up_cnt;
	logic [3:0] ld_cnt;
	logic [3:0] rq_cnt;
	logic [3:0] pa_cnt;
	logic       rc_q;
	wire logic  mapped;

	// Address decode of the five registers
	assign mapped = (paddr_i == REG_OUTPUT_ENABLE) || (paddr_i == REG_SB_MASK) ||
		(paddr_i == REG_SB_READBACK) || (paddr_i == REG_PIN_MAP) || (paddr_i == REG_STATUS);

	// Saturating counts: since reset, load low, ref clock quiet, pin a high
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up_cnt <= 4'h0;
			ld_cnt <= 4'h0;
			rq_cnt <= 4'h0;
			pa_cnt <= 4'h0;
			rc_q   <= 1'b0;
		end else begin
			up_cnt <= (up_cnt == 4'hF) ? up_cnt : up_cnt + 4'h1;
			ld_cnt <= enable_pin_g_or_shift_load_n_i ? 4'h0 : ((ld_cnt == 4'hF) ? ld_cnt : ld_cnt + 4'h1);
			rq_cnt <= (reference_input_clock_i != rc_q) ? 4'h0 : ((rq_cnt == 4'hF) ? rq_cnt : rq_cnt + 4'h1);
			pa_cnt <= !enable_pin_a_n_i ? 4'h0 : ((pa_cnt == 4'hF) ? pa_cnt : pa_cnt + 4'h1);
			rc_q   <= reference_input_clock_i;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// ************************************************************
	// Assertions
	// ************************************************************
	AST_PREADY: assert property (psel_i |-> pready_o)
		else $error("pready low during a transfer");
	AST_SLVERR: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
		else $error("slave error does not match address decode");
	AST_RDZERO: assert property (psel_i && !penable_i && !pwrite_i && !mapped |=> prdata_o == 32'h0)
		else $error("unmapped read returned nonzero data");
	AST_OE_ON: assert property (up_cnt == 4'hF && side_band_enable_strap_i |-> enable_pin_h_or_serial_out_oe_o)
		else $error("serial out not driven with strap high");
	AST_OE_STRAP: assert property (enable_pin_h_or_serial_out_oe_o |-> side_band_enable_strap_i)
		else $error("serial out driven with strap low");
	AST_SOUT_HOLD: assert property (ld_cnt >= 4'hA |-> $stable(enable_pin_h_or_serial_out_o))
		else $error("serial out moved while load low");
	AST_EN_REFCLK: assert property (rq_cnt >= 4'hA |-> $stable(clk_enable_o))
		else $error("enables changed without reference clock");
	AST_PIN_A: assert property (pa_cnt == 4'hF && $rose(reference_input_clock_i) |-> ##[1:8] !clk_enable_o[0])
		else $error("output 0 still enabled with pin a high");

	// Main scenarios
	CV_LOAD: cover property ($fell(enable_pin_g_or_shift_load_n_i));
	CV_ERR: cover property (psel_i && penable_i && pslverr_o);
	CV_OFF: cover property (rq_cnt == 4'hF && !clk_enable_o[0]);
endmodule

bind oes_top oes_chk #(.N_OUT(N_OUT)) u_chk (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .prdata_o, .pready_o, .pslverr_o, .enable_pin_a_n_i,
	.enable_pin_g_or_shift_load_n_i, .enable_pin_h_or_serial_out_o,
	.enable_pin_h_or_serial_out_oe_o, .side_band_enable_strap_i,
	.reference_input_clock_i, .clk_enable_o);

`default_nettype wire

// ### tb/oes_sb_ctrl.sv
// Purpose: Side-band controller model shifting enable patterns
// Assumes: Own 125 ns serial clock, unrelated to the system clock
// Notes:   Clock stands low and load low between frames
`default_nettype none

module oes_sb_ctrl
	import oes_pkg::*;
(
	output var oes_sb_pins_type pins_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle: clock low, load low, data parked
	initial pins_o = '{sclk: 1'b0, sin: 1'b0, load_n: 1'b0};

	// One frame: load high, 16 bits top first, clock low, load falls
	task send(input logic [15:0] v);
		pins_o.load_n = 1'b1;
		#62.5;
		for (int i = 15; i >= 0; i--) begin
			pins_o.sin = v[i];
			#62.5;
			pins_o.sclk = 1'b1;
			#62.5;
			pins_o.sclk = 1'b0;
		end
		#62.5;
		pins_o.load_n = 1'b0;
		pins_o.sin = ~v[0];
	endtask

	// Clock and data activity with load held low
	task noise();
		for (int i = 0; i < 4; i++) begin
			pins_o.sin = ~pins_o.sin;
			#62.5;
			pins_o.sclk = 1'b1;
			#62.5;
			pins_o.sclk = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// ### tb/oes_top_tb_top.sv
// Purpose: Self-checking bench for the enable side-band block
// Assumes: Strap high on dut, low on dut_nosb, pin map at reset, APB master in bench
// Notes:   Reference clock 12.5 MHz, can be stopped
`default_nettype none

module oes_top_tb_top
	import oes_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic             clk_i = 1'b0;
	logic             nrst_i = 1'b0;
	logic             psel_i = 1'b0;
	logic             penable_i = 1'b0;
	logic             pwrite_i = 1'b0;
	logic [11:0]      paddr_i = 12'h000;
	logic [31:0]      pwdata_i = 32'h0;
	wire logic [31:0] prdata_o;
	wire logic        pready_o;
	wire logic        pslverr_o;
	wire logic        sout;
	wire logic        soe;
	wire logic        h_lvl;
	wire logic [15:0] en;
	wire logic [15:0] en0;
	logic [3:0]       pins = 4'h0;
	logic             pg = 1'b0;
	logic             refclk = 1'b0;
	logic             run = 1'b1;
	oes_sb_pins_type  sb;
	logic [31:0]      r;
	logic             e;
	logic [15:0]      m_sh, m_mask, m_oe, old;
	int               seed = 6;
	int               mismatches = 0;
	int               n_compared = 0;

	// Pin h pulled up when released
	assign h_lvl = soe ? sout : 1'b1;

	oes_top dut (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .enable_pin_a_n_i(pins[0]),
		.enable_pin_b_n_i(pins[1]), .enable_pin_c_n_i(pins[2]),
		.enable_pin_d_or_serial_clock_i(sb.sclk), .enable_pin_e_or_serial_in_i(sb.sin),
		.enable_pin_f_n_i(pins[3]), .enable_pin_g_or_shift_load_n_i(sb.load_n),
		.enable_pin_h_or_serial_out_i(h_lvl), .enable_pin_h_or_serial_out_o(sout),
		.enable_pin_h_or_serial_out_oe_o(soe), .side_band_enable_strap_i(1'b1),
		.smbus_enable_latch_n_i(1'b1), .power_good_powerdown_n_i(pg),
		.reference_input_clock_i(refclk), .clk_enable_o(en));

	// Same board pins except pin h, fed from pin b, with strap low; side-band must stay out of the result
	oes_top dut_nosb (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o(), .pready_o(), .pslverr_o(), .enable_pin_a_n_i(pins[0]),
		.enable_pin_b_n_i(pins[1]), .enable_pin_c_n_i(pins[2]),
		.enable_pin_d_or_serial_clock_i(sb.sclk), .enable_pin_e_or_serial_in_i(sb.sin),
		.enable_pin_f_n_i(pins[3]), .enable_pin_g_or_shift_load_n_i(sb.load_n),
		.enable_pin_h_or_serial_out_i(pins[1]), .enable_pin_h_or_serial_out_o(),
		.enable_pin_h_or_serial_out_oe_o(), .side_band_enable_strap_i(1'b0),
		.smbus_enable_latch_n_i(1'b1), .power_good_powerdown_n_i(pg),
		.reference_input_clock_i(refclk), .clk_enable_o(en0));

	oes_sb_ctrl ctrl (.pins_o(sb));

	// Clocks and watchdog
	initial forever #5 clk_i = ~clk_i;
	initial forever #40 if (run) refclk = ~refclk;
	initial begin
		#150000;
		mismatches++;
		$display("ERROR watchdog expired");
		complete_run();
	end

	// Reference model of the output enables
	function automatic logic [15:0] exp_en(input logic side_band_interface);
		logic [15:0] x;
		x = ((side_band_interface ? m_sh : 16'hFFFF) | m_mask) & m_oe;
		x[0] &= ~pins[0];
		x[2] &= ~pins[1];
		x[4] &= ~pins[2];
		x[10] &= ~pins[3];
		if (!side_band_interface) begin
			x[6] &= ~sb.sclk;
			x[8] &= ~sb.sin;
			x[12] &= ~sb.load_n;
			x[14] &= ~pins[1];
		end
		return x;
	endfunction

	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// One APB transfer, result left in r and e
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task wait_en();
		int k;
		k = 0;
		while ((en !== exp_en(1'b1) || en0 !== exp_en(1'b0)) && k < 100) begin
			@(posedge clk_i);
			k++;
		end
		chk("enables", {16'h0, exp_en(1'b1)}, {16'h0, en});
		chk("enables strap low", {16'h0, exp_en(1'b0)}, {16'h0, en0});
	endtask

	// Shift a frame, then check readback and serial out
	task frame(input logic [15:0] p);
		ctrl.send(p);
		m_sh = p;
		repeat (20) @(posedge clk_i);
		apb(1'b0, REG_SB_READBACK, 32'h0);
		chk("readback", {16'h0, p}, r);
		chk("serial out", {31'h0, p[15]}, {31'h0, sout});
	endtask

	task complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		m_sh = 16'hFFFF;
		m_mask = 16'h0;
		m_oe = 16'hFFFF;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		apb(1'b0, REG_SB_READBACK, 32'h0);
		chk("readback reset", 32'h0000FFFF, r);
		apb(1'b1, REG_SB_MASK, 32'hFFFF);
		apb(1'b0, REG_SB_MASK, 32'h0);
		chk("mask before power good", 32'h0, r);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h1, {29'h0, r[18:16]});
		wait_en();
		for (int i = 0; i < 4; i++) begin
			if (i == 2) begin
				pg <= 1'b1;
				repeat (10) @(posedge clk_i);
			end
			pins <= 4'($random(seed)) | {3'b000, i[0]};
			frame(16'($random(seed)));
			wait_en();
		end
		m_mask = 16'($random(seed));
		apb(1'b1, REG_SB_MASK, {16'h0, m_mask});
		apb(1'b0, REG_SB_MASK, 32'h0);
		chk("mask", {16'h0, m_mask}, r);
		wait_en();
		m_oe = 16'($random(seed));
		apb(1'b1, REG_OUTPUT_ENABLE, {16'h0, m_oe});
		wait_en();
		apb(1'b1, REG_SB_READBACK, 32'h0);
		apb(1'b0, REG_SB_READBACK, 32'h0);
		chk("readback after write", {16'h0, m_sh}, r);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		ctrl.noise();
		repeat (20) @(posedge clk_i);
		apb(1'b0, REG_SB_READBACK, 32'h0);
		chk("readback after noise", {16'h0, m_sh}, r);
		run <= 1'b0;
		old = en;
		frame(~m_sh);
		repeat (40) @(posedge clk_i);
		chk("enables held", {16'h0, old}, {16'h0, en});
		run <= 1'b1;
		wait_en();
		complete_run();
	end
endmodule

`default_nettype wire
